// file: tmrsc_pkg.sv
package tmrsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int TMRSC_ADDR_W  = 8;               // Register address width
    localparam int TMRSC_DATA_W  = 32;              // Register data width
    localparam int TMRSC_COUNT_W = 16;              // Up-counter width
    localparam int TMRSC_EVT_W   = 3;               // Number of event sources

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] TMRSC_OFS_STATUS   = 8'h00;  // event_status
    localparam logic [7:0] TMRSC_OFS_IRQ_EN   = 8'h04;  // interrupt_enable
    localparam logic [7:0] TMRSC_OFS_SNAPSHOT = 8'h08;  // counter_snapshot
    localparam logic [7:0] TMRSC_OFS_CMP_A    = 8'h0c;  // compare_value_a
    localparam logic [7:0] TMRSC_OFS_CMP_B    = 8'h10;  // compare_value_b
    localparam logic [7:0] TMRSC_OFS_CAPT_A   = 8'h14;  // capture_value_a
    localparam logic [7:0] TMRSC_OFS_CTRL     = 8'h18;  // counter control

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int TMRSC_BIT_MATCH_A  = 0;  // match_a_flag / match_a_irq_enable
    localparam int TMRSC_BIT_MATCH_B  = 1;  // match_b_flag / match_b_irq_enable
    localparam int TMRSC_BIT_OVERFLOW = 2;  // overflow_flag / overflow_irq_enable
    localparam int TMRSC_BIT_CLEAR_EN = 0;  // counter_clear_enable in control

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [2:0]  TMRSC_RST_FLAGS = 3'h0;
    localparam logic [2:0]  TMRSC_RST_IRQEN = 3'h0;
    localparam logic [15:0] TMRSC_RST_COUNT = 16'h0000;
    localparam logic [15:0] TMRSC_RST_CMP   = 16'h0000;
    localparam logic [15:0] TMRSC_RST_CAPT  = 16'h0000;
    localparam logic        TMRSC_RST_CLEAR = 1'b0;
    localparam logic [31:0] TMRSC_RST_RDATA = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0]  addr;      // Byte address
        logic [31:0] wdata;     // Write data
        logic        wr;        // Write strobe
        logic        rd;        // Read strobe
    } tmrsc_req_t;

    // Bit order matches the status and enable layout
    typedef struct packed {
        logic overflow;         // Bit 2
        logic matchB;           // Bit 1
        logic matchA;           // Bit 0
    } tmrsc_evt_t;

    ////////////////////////////////////////////////////////////////////////
    // Zero-extend a narrow field into a read word
    function automatic logic [31:0] tmrsc_zext16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    function automatic logic [31:0] tmrsc_zext3(input logic [2:0] v);
        return {29'h0000_0000, v};
    endfunction

endpackage

// file: tmrsc_counter.sv
module tmrsc_counter
    import tmrsc_pkg::*;
#(
    parameter int CW = TMRSC_COUNT_W
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Control
    input  wire logic          tick,       // One count step, same clock
    input  wire logic          clearEn,    // counter_clear_enable
    input  wire logic [CW-1:0] cmpA,       // compare_a_field
    input  wire logic [CW-1:0] cmpB,       // compare_b_field
    // Results
    output logic      [CW-1:0] count,      // live_count_field
    output tmrsc_evt_t         evt         // One-cycle event pulses
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [CW-1:0] count_r;                // Up-counter
    logic [CW-1:0] count_nxt;
    logic          hitA;                   // Count equals compare A
    logic          hitB;                   // Count equals compare B
    logic          wrap;                   // Count at its top value

    ////////////////////////////////////////////////////////////////////////
    // Next count and events; events only fire on a tick so a count that
    // rests on a compare value does not raise the flag again every cycle
    always_comb begin
        hitA      = (count_r == cmpA);
        hitB      = (count_r == cmpB);
        wrap      = (count_r == {CW{1'b1}});
        count_nxt = count_r;
        evt       = '0;
        if (tick) begin
            evt.matchA = hitA;
            evt.matchB = hitB;
            if (hitB && clearEn) begin
                // Clear on match B takes the place of the step
                count_nxt = '0;
            end else begin
                // Without clearing the count runs past match B
                count_nxt    = count_r + 1'b1;
                evt.overflow = wrap;
            end
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_r <= CW'(TMRSC_RST_COUNT);
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule

// file: tmrsc_flags.sv
module tmrsc_flags
    import tmrsc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Events and controls
    input  tmrsc_evt_t      evt,        // Event pulses
    input  wire logic       rdClear,    // Status register is being read
    input  wire logic [2:0] irqEn,      // interrupt_enable bits
    // Results
    output logic      [2:0] flags,      // Sticky event flags
    output logic            irq         // Level interrupt request
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [2:0] flags_r;
    logic [2:0] flags_nxt;
    logic       irq_r;
    logic       irq_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Read clears every flag, but an event in the same cycle wins so it is
    // never lost; flags set regardless of the enables
    always_comb begin
        flags_nxt = flags_r;
        if (rdClear) begin
            flags_nxt = '0;
        end
        flags_nxt = flags_nxt | evt;
        // Only enabled sources reach the request line
        irq_nxt   = |(flags_nxt & irqEn);
    end

    // Register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_r <= TMRSC_RST_FLAGS;
            irq_r   <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign flags = flags_r;
    assign irq   = irq_r;

endmodule

// file: tmrsc_top.sv
module tmrsc_top
    import tmrsc_pkg::*;
#(
    parameter int AW = TMRSC_ADDR_W,
    parameter int CW = TMRSC_COUNT_W
) (
    // Clock and reset
    clk,
    nrst,
    // Register port
    regAddr,
    regWdata,
    regWr,
    regRd,
    regRdata,
    // Counter drive from the prescaler and capture logic
    countTick,
    captureStrobe,
    // Interrupt request
    irq
);

    ////////////////////////////////////////////////////////////////////////
    // Port declarations
    // Clock and reset
    input  wire logic          clk;            // 200 MHz
    input  wire logic          nrst;           // Synchronous, active low
    // Register port
    input  wire logic [AW-1:0] regAddr;        // Byte address
    input  wire logic [31:0]   regWdata;       // Write data
    input  wire logic          regWr;          // Write strobe
    input  wire logic          regRd;          // Read strobe
    output logic      [31:0]   regRdata;       // Read data, next cycle
    // Counter drive
    input  wire logic          countTick;      // Count step pulse
    input  wire logic          captureStrobe;  // Load capture_value_a
    // Interrupt request
    output logic               irq;            // Level request

    ////////////////////////////////////////////////////////////////////////
    // Bus request bundle
    tmrsc_req_t req;                           // Current bus request

    always_comb begin
        req       = '0;
        req.addr  = regAddr[7:0];
        req.wdata = regWdata;
        req.wr    = regWr;
        req.rd    = regRd;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode; a full match on all address bits so aliases above
    // the map are unmapped rather than folding onto a register
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0]    ofs);
        return (a == AW'(ofs));
    endfunction

    logic selStatus;                           // event_status
    logic selIrqEn;                            // interrupt_enable
    logic selSnap;                             // counter_snapshot
    logic selCmpA;                             // compare_value_a
    logic selCmpB;                             // compare_value_b
    logic selCaptA;                            // capture_value_a
    logic selCtrl;                             // counter control

    always_comb begin
        selStatus = hit(regAddr, TMRSC_OFS_STATUS);
        selIrqEn  = hit(regAddr, TMRSC_OFS_IRQ_EN);
        selSnap   = hit(regAddr, TMRSC_OFS_SNAPSHOT);
        selCmpA   = hit(regAddr, TMRSC_OFS_CMP_A);
        selCmpB   = hit(regAddr, TMRSC_OFS_CMP_B);
        selCaptA  = hit(regAddr, TMRSC_OFS_CAPT_A);
        selCtrl   = hit(regAddr, TMRSC_OFS_CTRL);
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers
    logic [2:0]    irqEn_r;                    // Interrupt enables
    logic [2:0]    irqEn_nxt;
    logic [CW-1:0] cmpA_r;                     // compare_a_field
    logic [CW-1:0] cmpA_nxt;
    logic [CW-1:0] cmpB_r;                     // compare_b_field
    logic [CW-1:0] cmpB_nxt;
    logic          clearEn_r;                  // counter_clear_enable
    logic          clearEn_nxt;

    // Write decode; writes to read-only or unmapped words are dropped
    always_comb begin
        irqEn_nxt   = irqEn_r;
        cmpA_nxt    = cmpA_r;
        cmpB_nxt    = cmpB_r;
        clearEn_nxt = clearEn_r;
        if (req.wr) begin
            if (selIrqEn) begin
                // Only the three enable bits exist, the rest are dropped
                irqEn_nxt[TMRSC_BIT_OVERFLOW] =
                    req.wdata[TMRSC_BIT_OVERFLOW];
                irqEn_nxt[TMRSC_BIT_MATCH_B]  =
                    req.wdata[TMRSC_BIT_MATCH_B];
                irqEn_nxt[TMRSC_BIT_MATCH_A]  =
                    req.wdata[TMRSC_BIT_MATCH_A];
            end
            if (selCmpA) begin
                cmpA_nxt = req.wdata[CW-1:0];
            end
            if (selCmpB) begin
                cmpB_nxt = req.wdata[CW-1:0];
            end
            if (selCtrl) begin
                clearEn_nxt = req.wdata[TMRSC_BIT_CLEAR_EN];
            end
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqEn_r   <= TMRSC_RST_IRQEN;
            cmpA_r    <= CW'(TMRSC_RST_CMP);
            cmpB_r    <= CW'(TMRSC_RST_CMP);
            clearEn_r <= TMRSC_RST_CLEAR;
        end else begin
            irqEn_r   <= irqEn_nxt;
            cmpA_r    <= cmpA_nxt;
            cmpB_r    <= cmpB_nxt;
            clearEn_r <= clearEn_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Up-counter with compare detection
    logic [CW-1:0] count;                      // live_count_field
    tmrsc_evt_t    evt;                        // Event pulses

    tmrsc_counter #(
        .CW      (CW)
    ) u_counter (
        .clk     (clk),
        .nrst    (nrst),
        .tick    (countTick),
        .clearEn (clearEn_r),
        .cmpA    (cmpA_r),
        .cmpB    (cmpB_r),
        .count   (count),
        .evt     (evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and interrupt request
    logic [2:0] flags;                         // Event flags
    logic       statusRead;                    // Status read this cycle

    // A read clears; a write to the status word has no effect
    always_comb begin
        statusRead = req.rd && selStatus;
    end

    tmrsc_flags u_flags (
        .clk     (clk),
        .nrst    (nrst),
        .evt     (evt),
        .rdClear (statusRead),
        .irqEn   (irqEn_r),
        .flags   (flags),
        .irq     (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Capture register; the trigger source lives outside this block
    logic [CW-1:0] captA_r;                    // capture_a_field
    logic [CW-1:0] captA_nxt;

    always_comb begin
        captA_nxt = captA_r;
        if (captureStrobe) begin
            captA_nxt = count;
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            captA_r <= CW'(TMRSC_RST_CAPT);
        end else begin
            captA_r <= captA_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; data stands only in the cycle after the strobe and is
    // zero otherwise, which also makes unmapped reads return zero
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb begin
        rdata_nxt = '0;
        if (req.rd) begin
            if (selStatus) begin
                // Old flag values; the clear lands at the same edge
                rdata_nxt = tmrsc_zext3(flags);
            end else if (selIrqEn) begin
                rdata_nxt = tmrsc_zext3(irqEn_r);
            end else if (selSnap) begin
                // Sampled at the read strobe, upper half zero
                rdata_nxt = tmrsc_zext16(16'(count));
            end else if (selCmpA) begin
                rdata_nxt = tmrsc_zext16(16'(cmpA_r));
            end else if (selCmpB) begin
                rdata_nxt = tmrsc_zext16(16'(cmpB_r));
            end else if (selCaptA) begin
                rdata_nxt = tmrsc_zext16(16'(captA_r));
            end else if (selCtrl) begin
                rdata_nxt[TMRSC_BIT_CLEAR_EN] = clearEn_r;
            end else begin
                // Unmapped address reads as zero
                rdata_nxt = '0;
            end
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= TMRSC_RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;

endmodule

// file: tmrsc_top_asserts.sv
module tmrsc_top_chk
    import tmrsc_pkg::*;
#(
    parameter int AW = TMRSC_ADDR_W,
    parameter int CW = TMRSC_COUNT_W
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          nrst,
    // Register port
    input wire logic [AW-1:0] regAddr,
    input wire logic [31:0]   regWdata,
    input wire logic          regWr,
    input wire logic          regRd,
    input wire logic [31:0]   regRdata,
    // Counter drive and interrupt
    input wire logic          countTick,
    input wire logic          captureStrobe,
    input wire logic          irq
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    // Steps of multi-cycle checks
    // Status read with no event that could refill a flag
    sequence stsQuiet;
        regRd && regAddr == TMRSC_OFS_STATUS && !countTick;
    endsequence
    sequence stsRead;
        regRd && regAddr == TMRSC_OFS_STATUS;
    endsequence
    // Snapshot read while the count holds still
    sequence snapQuiet;
        regRd && regAddr == TMRSC_OFS_SNAPSHOT && !countTick;
    endsequence
    sequence snapRead;
        regRd && regAddr == TMRSC_OFS_SNAPSHOT;
    endsequence
    // Every enable cleared in one write to the enable word
    sequence maskOff;
        regWr && regAddr == TMRSC_OFS_IRQ_EN && regWdata[2:0] == 3'h0;
    endsequence

    // Write then read of one compare register, a cycle apart
    property cmpBack(logic [7:0] ofs);
        logic [15:0] d;
        (regWr && regAddr == ofs, d = regWdata[15:0]) ##1 !regWr ##1 (regRd && regAddr == ofs)
            |=> regRdata == {16'h0000, d};
    endproperty

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_idle_rdata: assert property (!regRd |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_status_upper: assert property (stsRead |=> regRdata[31:3] == 29'h0000_0000)
        else $error("status upper bits not zero");
    chk_enable_upper: assert property (regRd && regAddr == TMRSC_OFS_IRQ_EN |=> regRdata[31:3] == 29'h0)
        else $error("enable upper bits not zero");
    chk_field_upper: assert property (regRd && (regAddr == TMRSC_OFS_SNAPSHOT || regAddr == TMRSC_OFS_CMP_A
        || regAddr == TMRSC_OFS_CMP_B) |=> regRdata[31:16] == 16'h0000)
        else $error("16-bit register upper half not zero");
    chk_read_clears: assert property (stsQuiet ##1 stsRead |=> regRdata == 32'h0000_0000)
        else $error("status not cleared by read");
    chk_snap_steady: assert property (snapQuiet ##1 snapRead |=> regRdata == $past(regRdata))
        else $error("snapshot moved without a tick");
    chk_cmpa_back: assert property (cmpBack(TMRSC_OFS_CMP_A))
        else $error("compare A readback wrong");
    chk_cmpb_back: assert property (cmpBack(TMRSC_OFS_CMP_B))
        else $error("compare B readback wrong");
    chk_mask_quiet: assert property (maskOff ##1 !(regWr && regAddr == TMRSC_OFS_IRQ_EN) |=> !irq)
        else $error("interrupt with all sources disabled");
endmodule

bind tmrsc_top tmrsc_top_chk #(.AW(AW), .CW(CW)) uChk (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .countTick(countTick), .captureStrobe(captureStrobe), .irq(irq)
);

// file: tb_timer_status_compare_regs.sv
module tb_timer_status_compare_regs
    import tmrsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Design ports
    logic        clk;
    logic        nrst;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        countTick;
    logic        captureStrobe;
    logic        irq;
    // Score keeping
    int          miscompares;
    int          cmpCount;
    int          cycles;

    tmrsc_top #(.AW(8), .CW(16)) dut (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .countTick(countTick), .captureStrobe(captureStrobe), .irq(irq)
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the end of the tests or from the ceiling
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Ceiling: the full wrap alone needs about 65.5k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles: one strobe cycle each, data seen just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // Optional tick in the same cycle as the read
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic tk = 1'b0);
        @(posedge clk);
        regRd     <= 1'b1;
        regAddr   <= a;
        countTick <= tk;
        @(posedge clk);
        regRd     <= 1'b0;
        countTick <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask

    // Two reads with no gap
    task automatic rd2(input logic [7:0] a, input logic [31:0] e1, input logic [31:0] e2);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        #1;
        chk(regRdata, e1);
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e2);
    endtask

    // Count steps on consecutive cycles
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            countTick <= 1'b1;
        end
        @(posedge clk);
        countTick <= 1'b0;
    endtask

    // Interrupt follows its cause one cycle later
    task automatic chkIrq(input logic e);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic doReset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // Idle bus and held reset from time zero
        clk           = 1'b0;
        nrst          = 1'b0;
        regAddr       = 8'h00;
        regWdata      = 32'h0;
        regWr         = 1'b0;
        regRd         = 1'b0;
        countTick     = 1'b0;
        captureStrobe = 1'b0;
        miscompares   = 0;
        cmpCount      = 0;
        cycles        = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, the unmapped place at the end included
        for (int a = 0; a <= 'h1c; a += 4) begin
            rd(8'(a), 32'h0);
        end
        wr(TMRSC_OFS_IRQ_EN, 32'hffff_ffff);
        rd(TMRSC_OFS_IRQ_EN, 32'h0000_0007);
        wr(TMRSC_OFS_CMP_A, 32'hdead_1234);
        rd(TMRSC_OFS_CMP_A, 32'h0000_1234);
        wr(TMRSC_OFS_CMP_B, 32'hbeef_5678);
        rd(TMRSC_OFS_CMP_B, 32'h0000_5678);
        wr(TMRSC_OFS_STATUS, 32'hffff_ffff);
        rd(TMRSC_OFS_STATUS, 32'h0);
        wr(TMRSC_OFS_SNAPSHOT, 32'h0000_abcd);
        rd(TMRSC_OFS_SNAPSHOT, 32'h0);
        doReset();
        rd(TMRSC_OFS_CMP_A, 32'h0);
        rd(TMRSC_OFS_IRQ_EN, 32'h0);
        $display("Test registers done");
        // Flags and their interrupt gating, one source at a time
        wr(TMRSC_OFS_CMP_A, 32'h5);
        wr(TMRSC_OFS_CMP_B, 32'h9);
        tick(3);
        rd(TMRSC_OFS_SNAPSHOT, 32'h3);
        rd(TMRSC_OFS_STATUS, 32'h0);
        tick(3);
        wr(TMRSC_OFS_IRQ_EN, 32'h6);
        chkIrq(1'b0);
        wr(TMRSC_OFS_IRQ_EN, 32'h1);
        chkIrq(1'b1);
        rd(TMRSC_OFS_STATUS, 32'h1);
        chkIrq(1'b0);
        rd(TMRSC_OFS_STATUS, 32'h0);
        tick(4);
        wr(TMRSC_OFS_IRQ_EN, 32'h5);
        chkIrq(1'b0);
        wr(TMRSC_OFS_IRQ_EN, 32'h2);
        chkIrq(1'b1);
        rd(TMRSC_OFS_STATUS, 32'h2);
        // Run from 10 through the wrap; compares 5 and 9 stay behind
        tick(65526);
        wr(TMRSC_OFS_IRQ_EN, 32'h3);
        chkIrq(1'b0);
        wr(TMRSC_OFS_IRQ_EN, 32'h4);
        chkIrq(1'b1);
        wr(TMRSC_OFS_IRQ_EN, 32'h0);
        chkIrq(1'b0);
        rd(TMRSC_OFS_SNAPSHOT, 32'h0);
        rd(TMRSC_OFS_STATUS, 32'h4);
        $display("Test flags done");
        // Clear on compare B, then free running past it
        wr(TMRSC_OFS_CTRL, 32'h1);
        wr(TMRSC_OFS_CMP_B, 32'h2);
        tick(3);
        rd(TMRSC_OFS_SNAPSHOT, 32'h0);
        rd(TMRSC_OFS_STATUS, 32'h2);
        wr(TMRSC_OFS_CTRL, 32'h0);
        tick(4);
        rd2(TMRSC_OFS_SNAPSHOT, 32'h4, 32'h4);
        rd2(TMRSC_OFS_STATUS, 32'h2, 32'h0);
        @(posedge clk);
        captureStrobe <= 1'b1;
        @(posedge clk);
        captureStrobe <= 1'b0;
        rd(TMRSC_OFS_CAPT_A, 32'h4);
        $display("Test clear done");
        // Match lands in the very cycle of the status read
        wr(TMRSC_OFS_CMP_A, 32'h4);
        rd(TMRSC_OFS_STATUS, 32'h0, 1'b1);
        rd(TMRSC_OFS_STATUS, 32'h1);
        $display("Test read collision done");
        complete_run();
    end
endmodule
